// ---- hw/rotate_shift_sbb_decode.sv ----
// Decoder for rotate, arithmetic shift, subtract with borrow, flag load and restore forms.
// Assumes opcode and ModR/M bytes arrive from same-clock fetch logic with inst_valid_i.
`timescale 1ns/1ns
`include "decode_consts.svh"
module rotate_shift_sbb_decode (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    inst_valid_i,
    input  wire logic                    prefix_0f_i,
    input  wire logic [7:0]              opcode_i,
    input  wire logic [7:0]              modrm_i,
    input  wire logic [7:0]              accumulator_high_byte_i,
    output logic                         ready_o,
    output logic                         busy_o,
    output logic                         done_o,
    output decode_pkg::op_t              op_o,
    output logic                         wide_o,
    output logic                         dir_to_reg_o,
    output logic                         has_modrm_o,
    output decode_pkg::count_src_t       count_src_o,
    output decode_pkg::imm_kind_t        imm_kind_o,
    output logic [2:0]                   sreg_o,
    output logic [8:0]                   flags_mod_o,
    output logic [8:0]                   flags_undef_o,
    output logic [8:0]                   flags_value_o,
    output logic                         illegal_o
);

    decode_pkg::dec_state_t st_r;
    decode_pkg::dec_state_t st_nxt;
    decode_pkg::clk_count_t cyc;
    logic                   acc;
    logic                   last;
    logic [2:0]             ext;
    logic                   is_reg;
    logic                   by_one;
    logic                   is_rotate;

    assign acc    = inst_valid_i && ready_o;
    assign ext    = modrm_i[5:3];
    assign is_reg = (modrm_i[7:6] == `MOD_REGISTER);
    assign by_one = (opcode_i[7:1] == `OPC_SHIFT_ONE);

    always_comb
    begin
        st_nxt    = st_r;
        cyc       = `CLK_SINGLE;
        is_rotate = (ext == `EXT_ROTATE_LEFT) || (ext == `EXT_ROTATE_RIGHT);
        if (acc)
        begin
            st_nxt      = '0;
            st_nxt.wide = opcode_i[0];
            if (prefix_0f_i)
            begin
                st_nxt.wide = 1'b1;
                if (opcode_i == `OPC_SMM_RESUME)
                begin
                    st_nxt.op        = decode_pkg::OP_SMM_RESUME;
                    st_nxt.flags_mod = `FLAGS_ALL;
                    cyc              = `CLK_SMM_RESUME;
                end
                else if (opcode_i == `OPC_SEG_RESTORE)
                begin
                    st_nxt.op        = decode_pkg::OP_SEGMENT_DESCRIPTOR_RESTORE;
                    st_nxt.has_modrm = 1'b1;
                    st_nxt.sreg      = ext;
                    cyc              = `CLK_RESTORE;
                end
                else if ((opcode_i == `OPC_TASK_RESTORE) && (ext == `EXT_ZERO))
                begin
                    st_nxt.op        = decode_pkg::OP_TASK_REG_RESTORE;
                    st_nxt.has_modrm = 1'b1;
                    cyc              = `CLK_RESTORE;
                end
                else if ((opcode_i == `OPC_LDT_RESTORE) && (ext == `EXT_ZERO))
                begin
                    st_nxt.op        = decode_pkg::OP_LOCAL_TABLE_RESTORE;
                    st_nxt.has_modrm = 1'b1;
                    cyc              = `CLK_RESTORE;
                end
                else
                begin
                    st_nxt.illegal = 1'b1;
                end
            end
            else if (opcode_i == `OPC_AH_TO_FLAGS)
            begin
                st_nxt.op        = decode_pkg::OP_AH_TO_FLAGS;
                st_nxt.wide      = 1'b0;
                st_nxt.flags_mod = 9'h01f;
                st_nxt.flags_value[`FLAG_SF] = accumulator_high_byte_i[`AH_BIT_SF];
                st_nxt.flags_value[`FLAG_ZF] = accumulator_high_byte_i[`AH_BIT_ZF];
                st_nxt.flags_value[`FLAG_AF] = accumulator_high_byte_i[`AH_BIT_AF];
                st_nxt.flags_value[`FLAG_PF] = accumulator_high_byte_i[`AH_BIT_PF];
                st_nxt.flags_value[`FLAG_CF] = accumulator_high_byte_i[`AH_BIT_CF];
            end
            else if (by_one || (opcode_i[7:1] == `OPC_SHIFT_LOW_REG)
                     || (opcode_i[7:1] == `OPC_SHIFT_IMM))
            begin
                st_nxt.has_modrm = 1'b1;
                if (by_one)
                begin
                    st_nxt.count_src = decode_pkg::CNT_ONE;
                    cyc = is_reg ? `CLK_SINGLE : `CLK_MEMORY_ONE;
                end
                else if (opcode_i[7:1] == `OPC_SHIFT_LOW_REG)
                begin
                    st_nxt.count_src = decode_pkg::CNT_LOW_BYTE_REG;
                end
                else
                begin
                    st_nxt.count_src = decode_pkg::CNT_IMM;
                    st_nxt.imm_kind  = decode_pkg::IMM_BYTE;
                end
                if (ext == `EXT_ROTATE_LEFT)
                begin
                    st_nxt.op = decode_pkg::OP_ROTATE_LEFT;
                end
                else if (ext == `EXT_ROTATE_RIGHT)
                begin
                    st_nxt.op = decode_pkg::OP_ROTATE_RIGHT;
                end
                else if (ext == `EXT_SHIFT_LEFT)
                begin
                    st_nxt.op = decode_pkg::OP_ARITH_SHIFT_LEFT;
                end
                else if (ext == `EXT_SHIFT_RIGHT)
                begin
                    st_nxt.op = decode_pkg::OP_ARITH_SHIFT_RIGHT;
                end
                else
                begin
                    st_nxt.illegal = 1'b1;
                end
                if (st_nxt.illegal)
                begin
                    // Unknown forms always take one clock, even with a memory operand.
                    st_nxt.flags_mod = `FLAGS_NONE;
                    cyc              = `CLK_SINGLE;
                end
                else if (is_rotate)
                begin
                    st_nxt.flags_mod[`FLAG_CF] = 1'b1;
                    st_nxt.flags_mod[`FLAG_OF] = by_one;
                    st_nxt.flags_undef[`FLAG_OF] = !by_one;
                end
                else
                begin
                    st_nxt.flags_mod = 9'h01b;
                    st_nxt.flags_mod[`FLAG_AF] = 1'b0;
                    st_nxt.flags_mod[`FLAG_OF] = by_one;
                    st_nxt.flags_undef[`FLAG_AF] = 1'b1;
                    st_nxt.flags_undef[`FLAG_OF] = !by_one;
                end
            end
            else if (opcode_i[7:2] == `OPC_SBB_MODRM)
            begin
                st_nxt.op         = decode_pkg::OP_SUBTRACT_BORROW;
                st_nxt.has_modrm  = 1'b1;
                st_nxt.dir_to_reg = opcode_i[1];
                st_nxt.flags_mod  = 9'h11f;
            end
            else if (opcode_i[7:1] == `OPC_SBB_ACC)
            begin
                st_nxt.op        = decode_pkg::OP_SUBTRACT_BORROW;
                st_nxt.imm_kind  = opcode_i[0] ? decode_pkg::IMM_FULL : decode_pkg::IMM_BYTE;
                st_nxt.flags_mod = 9'h11f;
            end
            else if ((opcode_i[7:2] == `OPC_GROUP_IMM) && (ext == `EXT_SBB))
            begin
                st_nxt.op        = decode_pkg::OP_SUBTRACT_BORROW;
                st_nxt.has_modrm = 1'b1;
                st_nxt.imm_kind  = (!opcode_i[0] || opcode_i[1]) ? decode_pkg::IMM_BYTE
                                                                 : decode_pkg::IMM_FULL;
                st_nxt.flags_mod = 9'h11f;
            end
            else
            begin
                st_nxt.illegal = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    clock_counter u_clock_counter (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (acc),
        .count_i (cyc),
        .busy_o  (busy_o),
        .last_o  (last)
    );

    // A new instruction may be taken in the last cycle of the current one.
    assign ready_o       = !busy_o || last;
    assign done_o        = last;
    assign op_o          = st_r.op;
    assign wide_o        = st_r.wide;
    assign dir_to_reg_o  = st_r.dir_to_reg;
    assign has_modrm_o   = st_r.has_modrm;
    assign count_src_o   = st_r.count_src;
    assign imm_kind_o    = st_r.imm_kind;
    assign sreg_o        = st_r.sreg;
    assign flags_mod_o   = st_r.flags_mod;
    assign flags_undef_o = st_r.flags_undef;
    assign flags_value_o = st_r.flags_value;
    assign illegal_o     = st_r.illegal;

    AST_SMM_RESUME_40: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && prefix_0f_i && opcode_i == `OPC_SMM_RESUME
        |=> flags_mod_o == `FLAGS_ALL && !done_o ##38 !done_o ##1 done_o)
        else $error("Resume did not finish after forty clocks.");

    AST_AH_TO_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i == `OPC_AH_TO_FLAGS
        |=> done_o && flags_mod_o == 9'h01f
            && flags_value_o[`FLAG_CF] == $past(accumulator_high_byte_i[`AH_BIT_CF]))
        else $error("High byte flag load wrong or slow.");

    AST_SEG_RESTORE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && prefix_0f_i && opcode_i == `OPC_SEG_RESTORE
        |=> sreg_o == $past(modrm_i[5:3]) && flags_mod_o == `FLAGS_NONE ##5 done_o)
        else $error("Segment restore wrong register or timing.");

    AST_TABLE_RESTORE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && prefix_0f_i && modrm_i[5:3] == `EXT_ZERO
            && (opcode_i == `OPC_TASK_RESTORE || opcode_i == `OPC_LDT_RESTORE)
        |=> (!illegal_o && !done_o)[*5] ##1 done_o)
        else $error("Task or table restore did not take six clocks.");

    AST_ROTATE_LEFT_REG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i[7:1] == `OPC_SHIFT_LOW_REG
            && modrm_i[5:3] == `EXT_ROTATE_LEFT
        |=> done_o && flags_mod_o == 9'h001 && flags_undef_o == 9'h100)
        else $error("Rotate left by count register flags wrong.");

    AST_ROTATE_RIGHT_MEM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && by_one && modrm_i[5:3] == `EXT_ROTATE_RIGHT && !is_reg
        |=> !done_o && flags_mod_o == 9'h101 ##1 done_o)
        else $error("Rotate right by one in memory not two clocks.");

    AST_ROTATE_RIGHT_REG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i[7:1] == `OPC_SHIFT_LOW_REG
            && modrm_i[5:3] == `EXT_ROTATE_RIGHT
        |=> done_o && op_o == decode_pkg::OP_ROTATE_RIGHT)
        else $error("Rotate right by count register not one clock.");

    AST_IMM_COUNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i[7:1] == `OPC_SHIFT_IMM
        |=> imm_kind_o == decode_pkg::IMM_BYTE && count_src_o == decode_pkg::CNT_IMM)
        else $error("Immediate count form lacks its count byte.");

    AST_SHIFT_LEFT_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && by_one && modrm_i[5:3] == `EXT_SHIFT_LEFT
        |=> flags_mod_o == 9'h11b && flags_undef_o == 9'h004)
        else $error("Shift left by one flags wrong.");

    AST_SHIFT_RIGHT_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && by_one && modrm_i[5:3] == `EXT_SHIFT_RIGHT && is_reg
        |=> done_o && flags_mod_o == 9'h11b)
        else $error("Shift right by one on register wrong.");

    AST_SHIFT_RIGHT_REG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i[7:1] == `OPC_SHIFT_LOW_REG
            && modrm_i[5:3] == `EXT_SHIFT_RIGHT
        |=> done_o && flags_undef_o == 9'h104 && flags_mod_o[`FLAG_CF])
        else $error("Shift right by count register flags wrong.");

    AST_SBB_IMM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i[7:2] == `OPC_GROUP_IMM && modrm_i[5:3] == `EXT_SBB
        |=> op_o == decode_pkg::OP_SUBTRACT_BORROW && flags_mod_o == 9'h11f && has_modrm_o)
        else $error("Immediate borrow subtract decode wrong.");

    AST_SBB_REG_REG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i[7:2] == `OPC_SBB_MODRM && is_reg
        |=> done_o && dir_to_reg_o == $past(opcode_i[1]))
        else $error("Register borrow subtract direction or timing wrong.");

    AST_SBB_ACC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i[7:1] == `OPC_SBB_ACC
        |=> !has_modrm_o && imm_kind_o != decode_pkg::IMM_NONE)
        else $error("Accumulator borrow subtract form wrong.");

    AST_WIDTH_BIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc && !prefix_0f_i && opcode_i[7:2] == `OPC_SBB_MODRM
        |=> wide_o == $past(opcode_i[0]))
        else $error("Operand width does not follow w bit.");

endmodule

// ---- common/decode_consts.svh ----
// Opcode values, field codes, flag bit positions and clock counts of the decoder.
// Assumes inclusion by bare name; holds definitions only.
`ifndef DECODE_CONSTS_SVH
`define DECODE_CONSTS_SVH

`define OPC_SMM_RESUME      8'haa
`define OPC_SEG_RESTORE     8'h79
`define OPC_LDT_RESTORE     8'h7b
`define OPC_TASK_RESTORE    8'h7d
`define OPC_AH_TO_FLAGS     8'h9e
`define OPC_SHIFT_ONE       7'h68
`define OPC_SHIFT_LOW_REG   7'h69
`define OPC_SHIFT_IMM       7'h60
`define OPC_SBB_MODRM       6'h06
`define OPC_SBB_ACC         7'h0e
`define OPC_GROUP_IMM       6'h20

`define EXT_ROTATE_LEFT     3'h0
`define EXT_ROTATE_RIGHT    3'h1
`define EXT_SBB             3'h3
`define EXT_SHIFT_LEFT      3'h4
`define EXT_SHIFT_RIGHT     3'h7
`define EXT_ZERO            3'h0
`define MOD_REGISTER        2'h3

`define FLAG_OF             8
`define FLAG_DF             7
`define FLAG_IF             6
`define FLAG_TF             5
`define FLAG_SF             4
`define FLAG_ZF             3
`define FLAG_AF             2
`define FLAG_PF             1
`define FLAG_CF             0
`define FLAGS_ALL           9'h1ff
`define FLAGS_NONE          9'h000

`define AH_BIT_SF           7
`define AH_BIT_ZF           6
`define AH_BIT_AF           4
`define AH_BIT_PF           2
`define AH_BIT_CF           0

`define CLK_SMM_RESUME      6'h28
`define CLK_RESTORE         6'h06
`define CLK_SINGLE          6'h01
`define CLK_MEMORY_ONE      6'h02

`endif

// ---- common/decode_pkg.sv ----
// Types shared by the decoder and its clock counter.
// Assumes decode_consts.svh supplies the numeric constants.
package decode_pkg;

    typedef logic [5:0] clk_count_t;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_SMM_RESUME,
        OP_AH_TO_FLAGS,
        OP_SEGMENT_DESCRIPTOR_RESTORE,
        OP_TASK_REG_RESTORE,
        OP_LOCAL_TABLE_RESTORE,
        OP_ROTATE_LEFT,
        OP_ROTATE_RIGHT,
        OP_ARITH_SHIFT_LEFT,
        OP_ARITH_SHIFT_RIGHT,
        OP_SUBTRACT_BORROW
    } op_t;

    typedef enum logic [1:0] {
        CNT_NONE,
        CNT_ONE,
        CNT_LOW_BYTE_REG,
        CNT_IMM
    } count_src_t;

    typedef enum logic [1:0] {
        IMM_NONE,
        IMM_BYTE,
        IMM_FULL
    } imm_kind_t;

    typedef struct packed {
        op_t        op;
        logic       wide;
        logic       dir_to_reg;
        logic       has_modrm;
        count_src_t count_src;
        imm_kind_t  imm_kind;
        logic [2:0] sreg;
        logic [8:0] flags_mod;
        logic [8:0] flags_undef;
        logic [8:0] flags_value;
        logic       illegal;
    } dec_state_t;

    typedef struct packed {
        clk_count_t cnt;
    } cnt_state_t;

endpackage

// ---- hw/clock_counter.sv ----
// Down counter that holds an instruction busy for its clock count.
// Assumes load_i is only raised when the previous count is in its last cycle or idle.
`timescale 1ns/1ns
module clock_counter (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   load_i,
    input  wire decode_pkg::clk_count_t count_i,
    output logic                        busy_o,
    output logic                        last_o
);

    decode_pkg::cnt_state_t st_r;
    decode_pkg::cnt_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (load_i)
        begin
            st_nxt.cnt = count_i;
        end
        else if (st_r.cnt != '0)
        begin
            st_nxt.cnt = st_r.cnt - 6'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign busy_o = (st_r.cnt != '0);
    assign last_o = (st_r.cnt == 6'h01);

endmodule

// ---- tb/rotate_shift_sbb_decode_tb_top.sv ----
// Self-checking bench for the rotate, shift, borrow-subtract and restore decoder.
// Assumes the decoder's own assertions run alongside; inputs change only by NBA at posedge.
`timescale 1ns/1ns
`include "decode_consts.svh"
module rotate_shift_sbb_decode_tb_top;
    logic                   clk_i = 1'b0;
    logic                   rst_n_i = 1'b0;
    logic                   inst_valid_i = 1'b0;
    logic                   prefix_0f_i = 1'b0;
    logic [7:0]             opcode_i = 8'h00;
    logic [7:0]             modrm_i = 8'h00;
    logic [7:0]             accumulator_high_byte_i = 8'h00;
    logic                   ready_o;
    logic                   busy_o;
    logic                   done_o;
    decode_pkg::op_t        op_o;
    logic                   wide_o;
    logic                   dir_to_reg_o;
    logic                   has_modrm_o;
    decode_pkg::count_src_t count_src_o;
    decode_pkg::imm_kind_t  imm_kind_o;
    logic [2:0]             sreg_o;
    logic [8:0]             flags_mod_o;
    logic [8:0]             flags_undef_o;
    logic [8:0]             flags_value_o;
    logic                   illegal_o;
    int                     errors = 0;
    int                     compares = 0;
    int                     cycles = 0;

    rotate_shift_sbb_decode u_dut (
        .clk_i                   (clk_i),
        .rst_n_i                 (rst_n_i),
        .inst_valid_i            (inst_valid_i),
        .prefix_0f_i             (prefix_0f_i),
        .opcode_i                (opcode_i),
        .modrm_i                 (modrm_i),
        .accumulator_high_byte_i (accumulator_high_byte_i),
        .ready_o                 (ready_o),
        .busy_o                  (busy_o),
        .done_o                  (done_o),
        .op_o                    (op_o),
        .wide_o                  (wide_o),
        .dir_to_reg_o            (dir_to_reg_o),
        .has_modrm_o             (has_modrm_o),
        .count_src_o             (count_src_o),
        .imm_kind_o              (imm_kind_o),
        .sreg_o                  (sreg_o),
        .flags_mod_o             (flags_mod_o),
        .flags_undef_o           (flags_undef_o),
        .flags_value_o           (flags_value_o),
        .illegal_o               (illegal_o)
    );

    always #10 clk_i = ~clk_i;

    task automatic finish_test();
        $display("Counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hang costs a mismatch and ends the run through the common report.
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            $display("Error at %0t: cycle ceiling reached", $time);
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Presents one instruction, waits for its accept and counts cycles up to done.
    task automatic exec(input logic p, input logic [7:0] opc, input logic [7:0] m,
                        input logic [7:0] ah, input int n_exp);
        int n;
        n = 0;
        @(posedge clk_i);
        inst_valid_i <= 1'b1;
        prefix_0f_i <= p;
        opcode_i <= opc;
        modrm_i <= m;
        accumulator_high_byte_i <= ah;
        @(negedge clk_i);
        while (ready_o !== 1'b1 && n < 100)
        begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
        inst_valid_i <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
            check(16'(busy_o), 16'h1, "busy");
        end
        while (done_o !== 1'b1 && n < 60);
        check(16'(n), 16'(n_exp), "clock count");
        check(16'(ready_o), 16'h1, "ready in done cycle");
    endtask

    task automatic dec(input decode_pkg::op_t op, input logic w, input logic [8:0] fm,
                       input logic [8:0] fu);
        check(16'(op_o), 16'(op), "op");
        check(16'(wide_o), 16'(w), "wide");
        check(16'(flags_mod_o), 16'(fm), "flags modified");
        check(16'(flags_undef_o), 16'(fu), "flags undefined");
        check(16'(illegal_o), 16'(op == decode_pkg::OP_NONE), "illegal");
    endtask

    task automatic t_system();
        exec(1'b1, 8'haa, 8'h00, 8'h00, 40);
        dec(decode_pkg::OP_SMM_RESUME, 1'b1, 9'h1ff, 9'h000);
        exec(1'b0, 8'h9e, 8'h00, 8'h96, 1);
        dec(decode_pkg::OP_AH_TO_FLAGS, 1'b0, 9'h01f, 9'h000);
        check(16'(flags_value_o), 16'h016, "flag values");
        exec(1'b1, 8'h79, 8'h18, 8'h00, 6);
        dec(decode_pkg::OP_SEGMENT_DESCRIPTOR_RESTORE, 1'b1, 9'h000, 9'h000);
        check(16'(sreg_o), 16'h3, "segment field");
        exec(1'b1, 8'h7d, 8'hc0, 8'h00, 6);
        dec(decode_pkg::OP_TASK_REG_RESTORE, 1'b1, 9'h000, 9'h000);
        exec(1'b1, 8'h7b, 8'h00, 8'h00, 6);
        dec(decode_pkg::OP_LOCAL_TABLE_RESTORE, 1'b1, 9'h000, 9'h000);
        exec(1'b1, 8'h7b, 8'h08, 8'h00, 1);
        dec(decode_pkg::OP_NONE, 1'b1, 9'h000, 9'h000);
        $display("Test system forms done");
    endtask

    task automatic t_rotate_shift();
        exec(1'b0, 8'hd3, 8'hc0, 8'h00, 1);
        dec(decode_pkg::OP_ROTATE_LEFT, 1'b1, 9'h001, 9'h100);
        check(16'(count_src_o), 16'(decode_pkg::CNT_LOW_BYTE_REG), "count");
        exec(1'b0, 8'hd1, 8'hc8, 8'h00, 1);
        dec(decode_pkg::OP_ROTATE_RIGHT, 1'b1, 9'h101, 9'h000);
        exec(1'b0, 8'hd0, 8'h08, 8'h00, 2);
        dec(decode_pkg::OP_ROTATE_RIGHT, 1'b0, 9'h101, 9'h000);
        exec(1'b0, 8'hd2, 8'hc9, 8'h00, 1);
        dec(decode_pkg::OP_ROTATE_RIGHT, 1'b0, 9'h001, 9'h100);
        exec(1'b0, 8'hc1, 8'he0, 8'h00, 1);
        dec(decode_pkg::OP_ARITH_SHIFT_LEFT, 1'b1, 9'h01b, 9'h104);
        check(16'(count_src_o), 16'(decode_pkg::CNT_IMM), "count");
        check(16'(imm_kind_o), 16'(decode_pkg::IMM_BYTE), "imm");
        exec(1'b0, 8'hd1, 8'he0, 8'h00, 1);
        dec(decode_pkg::OP_ARITH_SHIFT_LEFT, 1'b1, 9'h11b, 9'h004);
        exec(1'b0, 8'hd0, 8'h20, 8'h00, 2);
        check(16'(count_src_o), 16'(decode_pkg::CNT_ONE), "count");
        exec(1'b0, 8'hd0, 8'h38, 8'h00, 2);
        dec(decode_pkg::OP_ARITH_SHIFT_RIGHT, 1'b0, 9'h11b, 9'h004);
        exec(1'b0, 8'hd1, 8'hf8, 8'h00, 1);
        dec(decode_pkg::OP_ARITH_SHIFT_RIGHT, 1'b1, 9'h11b, 9'h004);
        exec(1'b0, 8'hd0, 8'h10, 8'h00, 1);
        dec(decode_pkg::OP_NONE, 1'b0, 9'h000, 9'h000);
        exec(1'b0, 8'hd3, 8'hf8, 8'h00, 1);
        dec(decode_pkg::OP_ARITH_SHIFT_RIGHT, 1'b1, 9'h01b, 9'h104);
        exec(1'b0, 8'hd3, 8'hd0, 8'h00, 1);
        dec(decode_pkg::OP_NONE, 1'b1, 9'h000, 9'h000);
        $display("Test rotate and shift forms done");
    endtask

    task automatic t_borrow();
        exec(1'b0, 8'h81, 8'hd8, 8'h00, 1);
        dec(decode_pkg::OP_SUBTRACT_BORROW, 1'b1, 9'h11f, 9'h000);
        check(16'(imm_kind_o), 16'(decode_pkg::IMM_FULL), "imm");
        exec(1'b0, 8'h83, 8'hd8, 8'h00, 1);
        check(16'(imm_kind_o), 16'(decode_pkg::IMM_BYTE), "imm");
        exec(1'b0, 8'h1a, 8'hc1, 8'h00, 1);
        dec(decode_pkg::OP_SUBTRACT_BORROW, 1'b0, 9'h11f, 9'h000);
        check(16'(dir_to_reg_o), 16'h1, "direction");
        exec(1'b0, 8'h19, 8'hc1, 8'h00, 1);
        check(16'(dir_to_reg_o), 16'h0, "direction");
        exec(1'b0, 8'h1d, 8'hff, 8'h00, 1);
        dec(decode_pkg::OP_SUBTRACT_BORROW, 1'b1, 9'h11f, 9'h000);
        check(16'(has_modrm_o), 16'h0, "modrm used");
        check(16'(imm_kind_o), 16'(decode_pkg::IMM_FULL), "imm");
        $display("Test borrow subtract forms done");
    endtask

    // A second instruction held during a restore is refused until the done cycle.
    task automatic t_back_to_back();
        exec(1'b1, 8'h79, 8'h28, 8'h00, 6);
        @(posedge clk_i);
        inst_valid_i <= 1'b1;
        prefix_0f_i <= 1'b1;
        opcode_i <= 8'h7d;
        modrm_i <= 8'h00;
        @(posedge clk_i);
        prefix_0f_i <= 1'b0;
        opcode_i <= 8'h9e;
        accumulator_high_byte_i <= 8'h41;
        repeat (5) @(negedge clk_i);
        check(16'(op_o), 16'(decode_pkg::OP_TASK_REG_RESTORE), "refused op");
        check(16'(ready_o), 16'h0, "ready while busy");
        @(negedge clk_i);
        check(16'(done_o), 16'h1, "done");
        @(posedge clk_i);
        inst_valid_i <= 1'b0;
        @(negedge clk_i);
        check(16'(op_o), 16'(decode_pkg::OP_AH_TO_FLAGS), "next op");
        check(16'(flags_value_o), 16'h009, "flag values");
        $display("Test back to back done");
    endtask

    task automatic t_reset_mid_run();
        @(posedge clk_i);
        inst_valid_i <= 1'b1;
        prefix_0f_i <= 1'b1;
        opcode_i <= 8'haa;
        @(posedge clk_i);
        inst_valid_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(negedge clk_i);
        check(16'(busy_o), 16'h0, "busy in reset");
        check(16'(op_o), 16'(decode_pkg::OP_NONE), "op in reset");
        check(16'(ready_o), 16'h1, "ready in reset");
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        exec(1'b1, 8'haa, 8'h00, 8'h00, 40);
        $display("Test reset mid run done");
    endtask

    initial
    begin
        repeat (6) @(negedge clk_i);
        check(16'(ready_o), 16'h1, "ready in reset");
        check(16'(busy_o), 16'h0, "busy in reset");
        check(16'(flags_mod_o), 16'h000, "flags in reset");
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_system();
        t_rotate_shift();
        t_borrow();
        t_back_to_back();
        t_reset_mid_run();
        finish_test();
    end
endmodule
